// [testbench/ddps_properties.sv]
// Purpose: port assertions for ddps_dual_pointer
// Assumes: outputs trail the aux register by one cycle
// Notes: bind at foot
`timescale 1ns/1ps
module ddps_props (
    input wire mclk, reset, regWrite, regRead, regInc, ptrInc, pointerSelect, bootEnable, generalPurposeFlag, bootHit,
    input wire [7:0] regAddr, regWdata, regRdata,
    input wire [15:0] progAddr, dataPointer
);
    // ====================
    // aux and pointer checks
    default clocking @(posedge mclk); endclocking
    default disable iff (reset);
    sequence wrAux; regWrite && !regInc && regAddr == 8'hA2; endsequence
    sequence rdAux; regRead && regAddr == 8'hA2; endsequence
    sequence incAux; regInc && regAddr == 8'hA2; endsequence
    chk_write_sel: assert property (wrAux |=> ##1 pointerSelect == $past(regWdata[0], 2)) else $error("sel");
    chk_write_flag: assert property (wrAux |=> ##1 generalPurposeFlag == $past(regWdata[3], 2)) else $error("flag");
    chk_write_boot: assert property (wrAux |=> ##1 bootEnable == $past(regWdata[5], 2)) else $error("boot");
    chk_inc_toggle: assert property (incAux |=> ##1 pointerSelect != $past(pointerSelect)
        && generalPurposeFlag == $past(generalPurposeFlag)) else $error("inc");
    chk_zero_bit: assert property (rdAux |=> regRdata[2] == 1'b0) else $error("bit2");
    chk_read_fields: assert property (rdAux |=> {regRdata[5], regRdata[3], regRdata[0]}
        == {bootEnable, generalPurposeFlag, pointerSelect}) else $error("rd");
    // bootHit may come from the register or its copy; only judged while they agree
    chk_boot_hit: assert property ($stable(bootEnable) |-> bootHit == ($past(bootEnable)
        && $past(progAddr) >= 16'hF800)) else $error("hit");
    chk_ptr_inc: assert property (ptrInc && !regWrite && !regInc |=> ##1
        dataPointer == $past(dataPointer) + 16'h0001) else $error("ptr");
endmodule
bind ddps_dual_pointer ddps_props u_props (.*);

// [testbench/ddps_xmem_model.sv]
// Purpose: external data memory reached by the core
// Assumes: combinational read
// Notes: content derived from address so each pointer is told apart
`timescale 1ns/1ps
module ddps_xmem_model (input wire [15:0] addr, output wire [7:0] rdata);
    assign rdata = addr[15:8] ^ addr[7:0];
endmodule

// [testbench/tb_top.sv]
// Purpose: self-checking bench for ddps_dual_pointer
// Assumes: 50 MHz mclk, sync reset
// Notes: aux table first, then hand tests
`timescale 1ns/1ps
module tb_top;
    reg mclk = 0, reset = 1, regWrite = 0, regRead = 0, regInc = 0, ptrInc = 0;
    reg [7:0] regAddr = 8'h00, regWdata = 8'h00;
    reg [15:0] progAddr = 16'h0000;
    wire [7:0] regRdata, xd;
    wire [15:0] dataPointer;
    wire pointerSelect, bootEnable, generalPurposeFlag, bootHit;
    integer n_errors = 0, total_checks = 0, cyc = 0, i;
    // rows of {write, expected}; bit 2 written high must be dropped
    localparam [95:0] ROWS = 96'h0101_0808_2020_2929_2D29_0000;
    ddps_dual_pointer u_dut (.*);
    ddps_xmem_model u_mem (.addr(dataPointer), .rdata(xd));
    initial forever #10 mclk = ~mclk;
    // ====================
    // tasks
    task summarize; begin
        $display("errors %0d checks %0d", n_errors, total_checks);
        if (n_errors == 0 && total_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    end endtask
    task chk(input [15:0] seen, input [15:0] exp); begin
        total_checks = total_checks + 1;
        if (seen !== exp) begin
            n_errors = n_errors + 1;
            $display("BAD %0t seen %h want %h", $time, seen, exp);
        end
    end endtask
    // k = {read, ptrInc, inc, write}; returns just after the taking edge
    task op(input [3:0] k, input [7:0] a, input [7:0] d); begin
        @(posedge mclk);
        {regRead, ptrInc, regInc, regWrite} <= k;
        regAddr <= a;
        regWdata <= d;
        @(posedge mclk);
        {regRead, ptrInc, regInc, regWrite} <= 4'h0;
        #1;
    end endtask
    task flags(input [7:0] aux); begin
        @(posedge mclk);
        #1;
        chk({bootEnable, generalPurposeFlag, pointerSelect}, {aux[5], aux[3], aux[0]});
        op(4'h8, 8'hA2, 8'h00);
        chk(regRdata & 8'h2D, aux);
    end endtask
    always @(posedge mclk) begin
        cyc = cyc + 1;
        if (cyc == 3000) begin
            n_errors = n_errors + 1;
            summarize;
        end
    end
    // ====================
    // sequence
    initial begin
        repeat (16) @(posedge mclk);
        reset <= 1'b0;
        op(4'h8, 8'hA2, 8'h00);
        chk(regRdata & 8'h2D, 8'h00);
        chk(dataPointer, 16'h0000);
        for (i = 0; i < 6; i = i + 1) begin
            op(4'h1, 8'hA2, ROWS[i*16+8 +: 8]);
            flags(ROWS[i*16 +: 8]);
        end
        op(4'h1, 8'hA2, 8'h08);
        op(4'h2, 8'hA2, 8'h00);
        flags(8'h09);
        op(4'h2, 8'hA2, 8'h00);
        flags(8'h08);
        op(4'h1, 8'h82, 8'h34);
        op(4'h1, 8'h83, 8'h12);
        op(4'h2, 8'hA2, 8'h00);
        op(4'h1, 8'h82, 8'hFF);
        op(4'h1, 8'h83, 8'hFF);
        op(4'h4, 8'h00, 8'h00);
        @(posedge mclk);
        #1;
        chk(dataPointer, 16'h0000);
        op(4'h2, 8'hA2, 8'h00);
        @(posedge mclk);
        #1;
        chk(dataPointer, 16'h1234);
        chk(xd, 8'h26);
        op(4'h1, 8'hA2, 8'h20);
        progAddr <= 16'hF800;
        repeat (2) @(posedge mclk);
        #1;
        chk(bootHit, 1'b1);
        progAddr <= 16'hF7FF;
        @(posedge mclk);
        #1;
        chk(bootHit, 1'b0);
        // pointer bytes read back through the selected pointer
        op(4'h8, 8'h82, 8'h00);
        chk(regRdata, 8'h34);
        @(posedge mclk);
        #1;
        chk(regRdata, 8'h00);
        op(4'h8, 8'h83, 8'h00);
        chk(regRdata, 8'h12);
        // increment away from the aux register is dropped
        op(4'h2, 8'h82, 8'h00);
        op(4'h8, 8'h82, 8'h00);
        chk(regRdata, 8'h34);
        op(4'h8, 8'h90, 8'h00);
        chk(regRdata, 8'h00);
        // reset in mid-run
        @(posedge mclk);
        reset <= 1'b1;
        repeat (2) @(posedge mclk);
        reset <= 1'b0;
        #1;
        chk(bootEnable, 1'b0);
        chk(dataPointer, 16'h0000);
        op(4'h8, 8'hA2, 8'h00);
        chk(regRdata, 8'h00);
        summarize;
    end
endmodule

// [verilog/ddps_consts.vh]
// Purpose: constants for the dual data pointer select block
// Assumes: core-side special register bus with 8-bit address and data
// Notes: definitions only
`ifndef DDPS_CONSTS_VH
`define DDPS_CONSTS_VH
// ==========================================
// register map
`define DDPS_AUX_ADDR 8'hA2
`define DDPS_PTR0_LO_ADDR 8'h82
`define DDPS_PTR0_HI_ADDR 8'h83
// ==========================================
// aux control field positions
`define DDPS_SEL_BIT 0
`define DDPS_ZERO_BIT 2
`define DDPS_FLAG_BIT 3
`define DDPS_BOOT_BIT 5
// writable bits: select, flag, boot
`define DDPS_AUX_WMASK 8'h29
`define DDPS_AUX_RESET 8'h00
// ==========================================
// boot window and widths
`define DDPS_BOOT_BASE 16'hF800
`define DDPS_PTR_RESET 16'h0000
`define DDPS_PTR_ONE 16'h0001
`define DDPS_BYTE_ZERO 8'h00
`endif

// [verilog/ddps_dual_pointer.v]
// Purpose: aux pointer/boot control register with dual data pointers
// Assumes: core performs one register access per cycle, same clock
// Notes: reserved bits read zero; all outputs registered
`timescale 1ns/1ps
`include "ddps_consts.vh"
module ddps_dual_pointer (
    // clock and reset
    input wire mclk,
    input wire reset,
    // core register access
    input wire [7:0] regAddr,
    input wire regWrite,
    input wire regRead,
    input wire regInc,
    input wire [7:0] regWdata,
    output reg [7:0] regRdata,
    // pointer operations
    input wire ptrInc,
    input wire [15:0] progAddr,
    // results
    output reg [15:0] dataPointer,
    output reg pointerSelect,
    output reg bootEnable,
    output reg generalPurposeFlag,
    output reg bootHit
);
    wire [15:0] firstPointer;
    wire [15:0] secondPointer;
    reg [7:0] aux_q;
    reg [7:0] aux_d;
    reg [7:0] rd_d;
    wire auxHit = (regAddr == `DDPS_AUX_ADDR);
    wire selNow = aux_q[`DDPS_SEL_BIT];
    // ==========================================
    // address decode
    // pointer bytes sit at one address pair; the select bit picks the target
    wire ptrLoHit = (regAddr == `DDPS_PTR0_LO_ADDR);
    wire ptrHiHit = (regAddr == `DDPS_PTR0_HI_ADDR);
    wire loadLoNow = regWrite && ptrLoHit;
    wire loadHiNow = regWrite && ptrHiHit;
    // increment only acts on the aux register; elsewhere it is dropped
    wire auxIncNow = auxHit && regInc;
    wire auxWriteNow = auxHit && regWrite;
    // boot window test against the program address
    wire inBootWindow = (progAddr >= `DDPS_BOOT_BASE);
    wire bootOn = aux_q[`DDPS_BOOT_BIT];
    wire flagNow = aux_q[`DDPS_FLAG_BIT];
    // ==========================================
    // aux control register
    always @* begin
        aux_d = aux_q;
        if (auxIncNow) begin
            // bit 1 held at zero stops the carry at bit 1, so only bit 0 toggles
            aux_d = (aux_q + 8'h01) & `DDPS_AUX_WMASK;
        end else if (auxWriteNow) begin
            aux_d = regWdata & `DDPS_AUX_WMASK;
        end
    end
    always @(posedge mclk) begin
        if (reset) begin
            aux_q <= `DDPS_AUX_RESET;
        end else begin
            aux_q <= aux_d;
        end
    end
    // ==========================================
    // pointers
    ddps_pointer_bank uBank (
        .mclk(mclk),
        .reset(reset),
        .sel(selNow),
        .loadLo(loadLoNow),
        .loadHi(loadHiNow),
        .loadData(regWdata),
        .incPtr(ptrInc),
        .firstPointer(firstPointer),
        .secondPointer(secondPointer)
    );
    wire [15:0] selPtr = selNow ? secondPointer : firstPointer;
    // ==========================================
    // read data; reserved bits read zero
    always @* begin
        rd_d = `DDPS_BYTE_ZERO;
        if (auxHit) begin
            rd_d = aux_q;
        end else if (ptrLoHit) begin
            rd_d = selPtr[7:0];
        end else if (ptrHiHit) begin
            rd_d = selPtr[15:8];
        end
    end
    // ==========================================
    // read data output
    // held at zero outside a read so a stale byte is never mistaken for data
    always @(posedge mclk) begin
        if (reset) begin
            regRdata <= `DDPS_BYTE_ZERO;
        end else if (regRead) begin
            regRdata <= rd_d;
        end else begin
            regRdata <= `DDPS_BYTE_ZERO;
        end
    end
    // ==========================================
    // selected pointer output
    // one cycle behind the pointer state; the move logic must allow for it
    always @(posedge mclk) begin
        if (reset) begin
            dataPointer <= `DDPS_PTR_RESET;
        end else begin
            dataPointer <= selPtr;
        end
    end
    // ==========================================
    // pointer select output
    always @(posedge mclk) begin
        if (reset) begin
            pointerSelect <= 1'b0;
        end else begin
            pointerSelect <= selNow;
        end
    end
    // ==========================================
    // boot enable output
    always @(posedge mclk) begin
        if (reset) begin
            bootEnable <= 1'b0;
        end else begin
            bootEnable <= bootOn;
        end
    end
    // ==========================================
    // user flag output
    // no hardware reads this flag; it is storage only
    always @(posedge mclk) begin
        if (reset) begin
            generalPurposeFlag <= 1'b0;
        end else begin
            generalPurposeFlag <= flagNow;
        end
    end
    // ==========================================
    // boot window hit
    // taken from the register itself, not the output copy, so the hit
    // and the enable output change on the same edge
    always @(posedge mclk) begin
        if (reset) begin
            bootHit <= 1'b0;
        end else if (bootOn && inBootWindow) begin
            bootHit <= 1'b1;
        end else begin
            bootHit <= 1'b0;
        end
    end
endmodule

// [verilog/ddps_pointer_bank.v]
// Purpose: two 16-bit data pointers, one selected at a time
// Assumes: select, load and increment come from the same clock domain
// Notes: unselected pointer changes only on reset
`timescale 1ns/1ps
`include "ddps_consts.vh"
module ddps_pointer_bank (
    // clock and reset
    input wire mclk,
    input wire reset,
    // control
    input wire sel,
    input wire loadLo,
    input wire loadHi,
    input wire [7:0] loadData,
    input wire incPtr,
    // state
    output wire [15:0] firstPointer,
    output wire [15:0] secondPointer
);
    reg [15:0] ptr_q [0:1];
    genvar i;
    // ==========================================
    // per-pointer storage
    generate
        for (i = 0; i < 2; i = i + 1) begin : gPtr
            // pointer 0 answers to a low select, pointer 1 to a high one
            wire hit = (i == 0) ? !sel : sel;
            always @(posedge mclk) begin
                if (reset) begin
                    ptr_q[i] <= `DDPS_PTR_RESET;
                end else if (hit && incPtr) begin
                    ptr_q[i] <= ptr_q[i] + `DDPS_PTR_ONE;
                end else if (hit && loadLo) begin
                    ptr_q[i] <= {ptr_q[i][15:8], loadData};
                end else if (hit && loadHi) begin
                    ptr_q[i] <= {loadData, ptr_q[i][7:0]};
                end
            end
        end
    endgenerate
    assign firstPointer = ptr_q[0];
    assign secondPointer = ptr_q[1];
endmodule
